/* rtl/qlc_line_ctrl.sv */
// four-line control registers, slot assignment and loopback paths
// assumes the wire transceivers exchange one byte per bearer and one pair
// per signalling channel each frame, on the bus bit clock
//
// How it works
// - reset leaves lines down, registers zero
// - detector enabled while a line is down
// - activate bit powers line up, clear downs
// - registers kept and accessible while down
// - loopbacks act only on activated lines
// - bit5 loops all wire data back
// - bit4 loops first bearer only
// - bit3 loops second bearer only
// - bit6 returns serial input to output
// - bit2 lets line status interrupt
// - bit1 set blocks signalling toward wire
// - bit0 set blocks signalling toward serial
// - backplane is 64 byte slots per frame
// - bearers on one port, signalling another
// - signalling uses 2-bit sub-slots, 256 per frame
// - frame starts at marker, slot zero
// - six slot registers per line
// - slot active output low while driving
// - slot bit7 enables that bearer
// - disabled tx bearer sends all ones
// - disabled rx bearer leaves output undriven
// - slot bits 5..0 give slot number
// - address nibbles pick line and register
// - status change latches interrupt, read clears
`timescale 1ns/100ps
`default_nettype none
module qlc_line_ctrl
  import qlc_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          mgmt_clk,
  input  wire logic          mgmt_sel_n,
  input  wire logic          mgmt_din,
  output logic               mgmt_dout,
  output logic               mgmt_dout_oe,
  output logic               int_n,
  input  wire logic [7:0]    line_state,
  output logic [3:0]         line_power_up,
  output logic [3:0]         line_detect_enable,
  input  wire logic          clk_bus,
  input  wire logic          frame_marker,
  input  wire logic          bearer_serial_in,
  output logic               bearer_serial_out,
  output logic               bearer_serial_oe,
  output logic               bearer_slot_active_n,
  input  wire logic          signalling_serial_in,
  output logic               signalling_serial_out,
  output logic               signalling_serial_oe,
  input  wire logic [31:0]   wire_rx_b1,
  input  wire logic [31:0]   wire_rx_b2,
  input  wire logic [7:0]    wire_rx_sig,
  output logic [31:0]        wire_tx_b1,
  output logic [31:0]        wire_tx_b2,
  output logic [7:0]         wire_tx_sig,
  output logic [3:0]         wire_tx_oe
);

  // ************************************************************
  // helpers
  // ************************************************************

  // address maps onto a stored register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[7:6] == 2'b00) && (a[3:1] != IDX_HOLE);
  endfunction

  // bearer slot register matches slot and is enabled
  function automatic logic slot_hit(input logic [7:0] r, input logic [5:0] s);
    slot_hit = r[SLOT_PASS_BIT] && (r[SLOT_NUM_MSB:0] == s);
  endfunction

  // status code with the error flavour folded away
  function automatic logic [1:0] fold(input logic [1:0] c);
    fold = c[1] ? 2'b11 : c;
  endfunction

  // ************************************************************
  // system side: register file
  // ************************************************************
  qlc_reg_if rif ();

  logic [7:0] regs_q   [NUM_LINES][REGS_PER_LINE]; // live registers
  logic [7:0] shadow_q [NUM_LINES][REGS_PER_LINE]; // frozen copy for crossing
  logic [7:0] state_q;     // previous line status
  logic       int_q;       // interrupt latch, high when pending
  logic       dirty_q;     // registers changed since last publish
  logic       req_q;       // publish toggle
  logic [1:0] ack_s_q;     // returned toggle, synchronised
  logic       seen_q;      // last toggle taken, bus side
  logic       publish;     // copy into shadow this cycle
  logic       wr_ok;       // accepted store
  logic       change;      // enabled status change this cycle
  logic       stat_rd;     // status read starts

  qlc_mgmt_port u_port (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .mgmt_clk     (mgmt_clk),
    .mgmt_sel_n   (mgmt_sel_n),
    .mgmt_din     (mgmt_din),
    .mgmt_dout    (mgmt_dout),
    .mgmt_dout_oe (mgmt_dout_oe),
    .rif          (rif)
  );

  assign wr_ok   = rif.wr_stb && reg_hit(rif.addr);
  assign stat_rd = rif.addr_stb && (rif.addr == STATUS_ADDR);
  assign publish = dirty_q && (req_q == ack_s_q[1]);

  // read data: old contents for the second byte, zero where unmapped
  always_comb begin
    if (rif.addr == STATUS_ADDR) begin
      rif.rdata = line_state;
    end else if (reg_hit(rif.addr)) begin
      rif.rdata = regs_q[rif.addr[5:4]][rif.addr[3:1]];
    end else begin
      rif.rdata = 8'h00;
    end
  end

  // store; works whether or not the line is powered up
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < NUM_LINES; l++) begin
      for (int r = 0; r < REGS_PER_LINE; r++) begin
        if (rst) begin
          regs_q[l][r] <= REG_RESET;
        end else if (wr_ok && rif.addr[5:4] == l[1:0] && rif.addr[3:1] == r[2:0]) begin
          // bit 6 of bearer slots is kept and read back, but no slot logic uses it
          regs_q[l][r] <= rif.wdata;
        end
      end
    end
  end

  // power and detector enables follow the activate bit
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < NUM_LINES; l++) begin
      if (rst) begin
        line_power_up[l]      <= 1'b0;
        line_detect_enable[l] <= 1'b1;
      end else begin
        line_power_up[l]      <= regs_q[l][IDX_CTRL][CTL_ACTIVATE];
        line_detect_enable[l] <= ~regs_q[l][IDX_CTRL][CTL_ACTIVATE];
      end
    end
  end

  // ************************************************************
  // system side: interrupt latch
  // ************************************************************
  always_comb begin
    change = 1'b0;
    for (int l = 0; l < NUM_LINES; l++) begin
      if (regs_q[l][IDX_CTRL][CTL_INT_EN] &&
          fold(line_state[2*l +: 2]) != fold(state_q[2*l +: 2])) begin
        change = 1'b1;
      end
    end
  end

  // a change in the clearing cycle still latches
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= 8'h00;
      int_q   <= 1'b0;
      int_n   <= 1'b1;
    end else begin
      state_q <= line_state;
      int_q   <= change | (int_q & ~stat_rd);
      int_n   <= ~(change | (int_q & ~stat_rd));
    end
  end

  // ************************************************************
  // crossing: handshake a frozen snapshot of all registers
  // ************************************************************

  // trade: one snapshot of the whole file keeps the crossing simple;
  // a write shows up on the bus side a few bit clocks later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dirty_q <= 1'b1;
      req_q   <= 1'b0;
      ack_s_q <= 2'b00;
    end else begin
      dirty_q <= wr_ok | (dirty_q & ~publish);
      ack_s_q <= {ack_s_q[0], seen_q};
      if (publish) begin
        req_q <= ~req_q;
      end
    end
  end

  // shadow only moves while no handshake is open
  always_ff @(posedge clk_sys) begin
    if (publish) begin
      shadow_q <= regs_q;
    end
  end

  // ************************************************************
  // bus side: reset, snapshot capture, frame position
  // ************************************************************
  logic [1:0] rst_s_q;     // reset carried into the bus clock
  logic [2:0] req_s_q;     // [0] first stage, [2] previous sample
  logic [7:0] cfg_q [NUM_LINES][REGS_PER_LINE]; // bus side copy
  logic       rst_bus;
  logic [FRAME_BIT_W-1:0] idx; // bit being sampled now; the serial outputs carry it one bus clock later

  assign rst_bus = rst_s_q[1];

  always_ff @(posedge clk_bus) begin
    rst_s_q <= {rst_s_q[0], rst};
    req_s_q <= {req_s_q[1:0], req_q};
  end

  // new snapshot taken when the toggle moves
  always_ff @(posedge clk_bus) begin
    if (rst_bus) begin
      seen_q <= 1'b0;
      for (int l = 0; l < NUM_LINES; l++) begin
        for (int r = 0; r < REGS_PER_LINE; r++) begin
          cfg_q[l][r] <= REG_RESET;
        end
      end
    end else if (req_s_q[1] != seen_q) begin
      seen_q <= req_s_q[1];
      cfg_q  <= shadow_q;
    end
  end

  qlc_frame_timer u_timer (
    .clk_bus      (clk_bus),
    .rst_bus      (rst_bus),
    .frame_marker (frame_marker),
    .bit_idx      (idx)
  );

  // ************************************************************
  // bus side: serial input capture
  // ************************************************************
  logic [6:0] bi_sh_q;               // first seven bits of the slot
  logic       di_prev_q;             // first bit of a sub-slot
  logic [7:0] bi_b1_q [NUM_LINES];   // first bearer from the backplane
  logic [7:0] bi_b2_q [NUM_LINES];   // second bearer from the backplane
  logic [1:0] di_q    [NUM_LINES];   // signalling pair from the backplane
  logic [7:0] bi_byte;               // completed slot byte

  assign bi_byte = {bi_sh_q, bearer_serial_in};

  // 64 eight-bit slots and 256 two-bit sub-slots per frame
  always_ff @(posedge clk_bus) begin
    bi_sh_q   <= bi_byte[6:0];
    di_prev_q <= signalling_serial_in;
    for (int l = 0; l < NUM_LINES; l++) begin
      if (rst_bus) begin
        bi_b1_q[l] <= IDLE_BYTE;
        bi_b2_q[l] <= IDLE_BYTE;
        di_q[l]    <= IDLE_SIG;
      end else begin
        if (idx[2:0] == 3'h7 && slot_hit(cfg_q[l][IDX_TX_B1], idx[8:3])) begin
          bi_b1_q[l] <= bi_byte;
        end
        if (idx[2:0] == 3'h7 && slot_hit(cfg_q[l][IDX_TX_B2], idx[8:3])) begin
          bi_b2_q[l] <= bi_byte;
        end
        if (idx[0] && idx[8:1] == cfg_q[l][IDX_TX_SIG]) begin
          di_q[l] <= {di_prev_q, signalling_serial_in};
        end
      end
    end
  end

  // ************************************************************
  // bus side: serial output selection
  // ************************************************************
  logic       bo_hit;   // some receive slot claims this bit
  logic [7:0] bo_byte;  // its byte
  logic       do_hit;   // some receive sub-slot claims this bit
  logic [1:0] do_pair;  // its pair
  logic       dig [NUM_LINES]; // digital loop on an active line

  // two bearers on one slot: the last match wins (highest line, second bearer over first); the real part gives undefined data
  always_comb begin
    bo_hit  = 1'b0;
    bo_byte = IDLE_BYTE;
    do_hit  = 1'b0;
    do_pair = IDLE_SIG;
    for (int l = 0; l < NUM_LINES; l++) begin
      dig[l] = cfg_q[l][IDX_CTRL][CTL_ACTIVATE] && cfg_q[l][IDX_CTRL][CTL_DIG_LOOP];
      if (slot_hit(cfg_q[l][IDX_RX_B1], idx[8:3])) begin
        bo_hit  = 1'b1;
        bo_byte = dig[l] ? bi_b1_q[l] : wire_rx_b1[8*l +: 8];
      end
      if (slot_hit(cfg_q[l][IDX_RX_B2], idx[8:3])) begin
        bo_hit  = 1'b1;
        bo_byte = dig[l] ? bi_b2_q[l] : wire_rx_b2[8*l +: 8];
      end
      if (!cfg_q[l][IDX_CTRL][CTL_SIG_RX_OFF] && idx[8:1] == cfg_q[l][IDX_RX_SIG]) begin
        do_hit  = 1'b1;
        do_pair = dig[l] ? di_q[l] : wire_rx_sig[2*l +: 2];
      end
    end
  end

  // msb of each slot first; undriven outside claimed slots
  always_ff @(posedge clk_bus) begin
    if (rst_bus) begin
      bearer_serial_out     <= 1'b0;
      bearer_serial_oe      <= 1'b0;
      bearer_slot_active_n  <= 1'b1;
      signalling_serial_out <= 1'b0;
      signalling_serial_oe  <= 1'b0;
    end else begin
      bearer_serial_out     <= bo_byte[~idx[2:0]];
      bearer_serial_oe      <= bo_hit;
      bearer_slot_active_n  <= ~bo_hit;
      signalling_serial_out <= do_pair[~idx[0]];
      signalling_serial_oe  <= do_hit;
    end
  end

  // ************************************************************
  // bus side: toward the wire, one instance of logic per line
  // ************************************************************
  always_ff @(posedge clk_bus) begin
    for (int l = 0; l < NUM_LINES; l++) begin
      if (rst_bus || !cfg_q[l][IDX_CTRL][CTL_ACTIVATE]) begin
        // a line that is down drives nothing and loops nothing
        wire_tx_b1[8*l +: 8]  <= 8'h00;
        wire_tx_b2[8*l +: 8]  <= 8'h00;
        wire_tx_sig[2*l +: 2] <= 2'h0;
        wire_tx_oe[l]         <= 1'b0;
      end else begin
        wire_tx_oe[l] <= 1'b1;
        if (cfg_q[l][IDX_CTRL][CTL_LINE_LOOP] || cfg_q[l][IDX_CTRL][CTL_B1_LOOP]) begin
          wire_tx_b1[8*l +: 8] <= wire_rx_b1[8*l +: 8];
        end else begin
          wire_tx_b1[8*l +: 8] <= cfg_q[l][IDX_TX_B1][SLOT_PASS_BIT] ? bi_b1_q[l] : IDLE_BYTE;
        end
        if (cfg_q[l][IDX_CTRL][CTL_LINE_LOOP] || cfg_q[l][IDX_CTRL][CTL_B2_LOOP]) begin
          wire_tx_b2[8*l +: 8] <= wire_rx_b2[8*l +: 8];
        end else begin
          wire_tx_b2[8*l +: 8] <= cfg_q[l][IDX_TX_B2][SLOT_PASS_BIT] ? bi_b2_q[l] : IDLE_BYTE;
        end
        if (cfg_q[l][IDX_CTRL][CTL_LINE_LOOP]) begin
          wire_tx_sig[2*l +: 2] <= wire_rx_sig[2*l +: 2];
        end else begin
          wire_tx_sig[2*l +: 2] <= cfg_q[l][IDX_CTRL][CTL_SIG_TX_OFF] ? IDLE_SIG : di_q[l];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/qlc_pkg.sv */
// constants shared by the four-line control and slot assignment block
// assumes a single 125 MHz system clock and one backplane bit clock
package qlc_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int NUM_LINES     = 4;     // independent lines
  localparam int REGS_PER_LINE = 8;     // one per even/odd code pair
  localparam int FRAME_BIT_W   = 9;     // 64 slots x 8 bits = 512 bit times

  // ************************************************************
  // register index (low nibble of the address byte, bit 0 dropped)
  // ************************************************************
  localparam logic [2:0] IDX_TX_SIG = 3'h0;  // tx_signalling_subslot
  localparam logic [2:0] IDX_TX_B1  = 3'h1;  // tx_first_bearer_slot
  localparam logic [2:0] IDX_TX_B2  = 3'h2;  // tx_second_bearer_slot
  localparam logic [2:0] IDX_RX_SIG = 3'h3;  // rx_signalling_subslot
  localparam logic [2:0] IDX_RX_B1  = 3'h4;  // rx_first_bearer_slot
  localparam logic [2:0] IDX_RX_B2  = 3'h5;  // rx_second_bearer_slot
  localparam logic [2:0] IDX_HOLE   = 3'h6;  // codes C/D: nothing there
  localparam logic [2:0] IDX_CTRL   = 3'h7;  // line_control_reg
  localparam logic [7:0] STATUS_ADDR = 8'hFF; // common status byte
  localparam logic [7:0] REG_RESET   = 8'h00; // every register after reset

  // ************************************************************
  // line control and slot register fields
  // ************************************************************
  localparam int CTL_ACTIVATE   = 7;  // activate_bit
  localparam int CTL_DIG_LOOP   = 6;  // serial in back to serial out
  localparam int CTL_LINE_LOOP  = 5;  // all channels wire in to wire out
  localparam int CTL_B1_LOOP    = 4;  // first bearer wire loop
  localparam int CTL_B2_LOOP    = 3;  // second bearer wire loop
  localparam int CTL_INT_EN     = 2;  // status change may interrupt
  localparam int CTL_SIG_TX_OFF = 1;  // signalling to wire disabled
  localparam int CTL_SIG_RX_OFF = 0;  // signalling to serial disabled
  localparam int SLOT_PASS_BIT  = 7;  // slot_pass_enable
  localparam int SLOT_NUM_MSB   = 5;  // slot_number is bits 5..0

  // ************************************************************
  // fill values and management framing
  // ************************************************************
  localparam logic [7:0] IDLE_BYTE = 8'hFF;  // all ones before scrambling
  localparam logic [1:0] IDLE_SIG  = 2'h3;   // all ones signalling pair
  localparam logic [4:0] ADDR_LAST = 5'h07;  // eighth sampled bit
  localparam logic [4:0] DATA_LAST = 5'h0F;  // sixteenth sampled bit

endpackage

/* rtl/qlc_reg_if.sv */
// register request bus between the management port and the register file
// assumes both ends run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface qlc_reg_if;
  logic       addr_stb;  // pulse: address byte complete
  logic       wr_stb;    // pulse: data byte complete on a write code
  logic [7:0] addr;      // latched address byte
  logic [7:0] wdata;     // data byte to store
  logic [7:0] rdata;     // contents at addr, combinational

  modport master (output addr_stb, output wr_stb, output addr, output wdata, input rdata);
  modport slave  (input addr_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/qlc_mgmt_port.sv */
// two-byte serial management port, oversampled on clk_sys
// assumes the serial clock is far slower than clk_sys
`timescale 1ns/100ps
`default_nettype none
module qlc_mgmt_port
  import qlc_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   mgmt_clk,
  input  wire logic   mgmt_sel_n,
  input  wire logic   mgmt_din,
  output logic        mgmt_dout,
  output logic        mgmt_dout_oe,
  qlc_reg_if.master   rif
);
  logic [2:0] clk_s_q;   // [0] is the first synchroniser stage only
  logic [1:0] sel_s_q;   // select synchroniser
  logic [1:0] din_s_q;   // data synchroniser
  logic [4:0] cnt_q;     // bits taken so far
  logic [7:0] sh_q;      // input shifter
  logic [7:0] out_q;     // output shifter
  logic       load_q;    // capture read data next cycle
  logic       rise;
  logic       fall;

  assign rise = clk_s_q[1] & ~clk_s_q[2];
  assign fall = ~clk_s_q[1] & clk_s_q[2];

  // pins are asynchronous: two stages before anything looks
  always_ff @(posedge clk_sys) begin
    clk_s_q <= {clk_s_q[1:0], mgmt_clk};
    sel_s_q <= {sel_s_q[0], mgmt_sel_n};
    din_s_q <= {din_s_q[0], mgmt_din};
  end

  // ************************************************************
  // sampling on rising serial clock
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    rif.addr_stb <= 1'b0;
    rif.wr_stb   <= 1'b0;
    if (rst || sel_s_q[1]) begin
      cnt_q <= 5'h00;
    end else if (rise) begin
      sh_q  <= {sh_q[6:0], din_s_q[1]};
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == ADDR_LAST) begin
        rif.addr     <= {sh_q[6:0], din_s_q[1]};
        rif.addr_stb <= 1'b1;
      end
      // even codes store, odd codes only read back
      if (cnt_q == DATA_LAST && !rif.addr[0]) begin
        rif.wdata  <= {sh_q[6:0], din_s_q[1]};
        rif.wr_stb <= 1'b1;
      end
    end
    if (rst) begin
      rif.addr  <= 8'h00;
      rif.wdata <= 8'h00;
      sh_q      <= 8'h00;
    end
  end

  // old contents go out on falling edges of the data byte
  always_ff @(posedge clk_sys) begin
    load_q <= rif.addr_stb;
    if (rst) begin
      out_q        <= 8'h00;
      mgmt_dout    <= 1'b0;
      mgmt_dout_oe <= 1'b0;
    end else begin
      mgmt_dout_oe <= ~sel_s_q[1];
      if (load_q) begin
        out_q <= rif.rdata;
      end else if (fall && cnt_q > ADDR_LAST) begin
        mgmt_dout <= out_q[7];
        out_q     <= {out_q[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/qlc_frame_timer.sv */
// bit position counter within the backplane frame
// assumes the frame marker is driven in step with the bus bit clock
`timescale 1ns/100ps
`default_nettype none
module qlc_frame_timer
  import qlc_pkg::*;
(
  input  wire logic                   clk_bus,
  input  wire logic                   rst_bus,
  input  wire logic                   frame_marker,
  output logic [FRAME_BIT_W-1:0]      bit_idx
);
  logic                   fm_q;   // marker one edge ago
  logic [FRAME_BIT_W-1:0] cnt_q;  // index of the bit taken at the last edge

  // first rising edge with marker high restarts at bit zero
  always_comb begin
    bit_idx = (frame_marker && !fm_q) ? '0 : cnt_q + 9'h001;
  end

  always_ff @(posedge clk_bus) begin
    if (rst_bus) begin
      fm_q  <= 1'b1;
      cnt_q <= '1;
    end else begin
      fm_q  <= frame_marker;
      cnt_q <= bit_idx;
    end
  end
endmodule
`default_nettype wire

/* sim/qlc_bus_model.sv */
// backplane model: bit clock, frame marker and a slot-numbered pattern
// assumes the block samples both serial inputs on the rising bus clock
`timescale 1ns/100ps
`default_nettype none
module qlc_bus_model (
  output logic       clk_bus,
  output logic       frame_marker,
  output logic       bearer_serial_in,
  output logic       signalling_serial_in,
  output logic [8:0] bit_pos
);
  // ****
  // bit clock and position
  // ****
  logic [7:0] pat;  // slot byte: 10 then the slot number
  logic [8:0] pos_q = 9'h000;  // bit position, one driver only
  initial begin  // free-running, offset so edges never meet clk_sys
    clk_bus = 1'b0;
    #3;
    forever #80 clk_bus = ~clk_bus;
  end
  // one bit a rising edge, wraps every 512 bits
  always @(posedge clk_bus) pos_q <= pos_q + 9'h001;
  assign bit_pos = pos_q;
  assign frame_marker = (bit_pos == 9'h000);
  assign pat = {2'b10, bit_pos[8:3]};  // tells each slot apart
  assign bearer_serial_in = pat[3'h7 - bit_pos[2:0]];
  assign signalling_serial_in = bearer_serial_in;
endmodule
`default_nettype wire

/* sim/qlc_line_ctrl_sva.sv */
// checker for the line control block, top ports only
// assumes rst reaches the bus side within a few bus clocks
`timescale 1ns/100ps
`default_nettype none
module qlc_line_ctrl_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_bus,
  input wire logic       mgmt_sel_n,
  input wire logic       mgmt_dout_oe,
  input wire logic       int_n,
  input wire logic [7:0] line_state,
  input wire logic [3:0] line_power_up,
  input wire logic [3:0] line_detect_enable,
  input wire logic       bearer_serial_oe,
  input wire logic       bearer_slot_active_n,
  input wire logic       signalling_serial_oe,
  input wire logic [3:0] wire_tx_oe
);
  // ****
  // slot sequences
  // ****
  sequence byte_slot; bearer_serial_oe [*8]; endsequence  // whole byte slot
  sequence pair_slot; signalling_serial_oe [*2]; endsequence  // whole sub-slot
  logic [1:0] rst_b_q;  // rst as the bus side sees it
  always_ff @(posedge clk_bus) rst_b_q <= {rst_b_q[0], rst};
  a_detect_when_down: assert property (@(posedge clk_sys) disable iff (rst)
    line_detect_enable == ~line_power_up) else $error("detector not inverse of power");
  a_reset_lines_down: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> line_power_up == 4'h0 && int_n) else $error("line up after reset");
  a_down_wire_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(line_power_up[0]) |-> ##[1:200] !wire_tx_oe[0]) else $error("wire still driven");
  a_int_needs_change: assert property (@(posedge clk_sys) disable iff (rst)
    $stable(line_state) && int_n |=> int_n) else $error("interrupt without change");
  a_mgmt_oe_idle: assert property (@(posedge clk_sys) disable iff (rst)
    mgmt_sel_n [*4] |-> !mgmt_dout_oe) else $error("dout driven unselected");
  a_slot_active_oe: assert property (@(posedge clk_bus) disable iff (rst || rst_b_q[1])
    bearer_slot_active_n == !bearer_serial_oe) else $error("slot active mismatch");
  a_bearer_whole_byte: assert property (@(posedge clk_bus) disable iff (rst || rst_b_q[1])
    $rose(bearer_serial_oe) |-> byte_slot) else $error("bearer slot cut short");
  a_sub_slot_pair: assert property (@(posedge clk_bus) disable iff (rst || rst_b_q[1])
    $rose(signalling_serial_oe) |-> pair_slot) else $error("sub-slot cut short");
endmodule
bind qlc_line_ctrl qlc_line_ctrl_sva chk (.clk_sys, .rst, .clk_bus, .mgmt_sel_n, .mgmt_dout_oe, .int_n,
  .line_state, .line_power_up, .line_detect_enable, .bearer_serial_oe, .bearer_slot_active_n,
  .signalling_serial_oe, .wire_tx_oe);
`default_nettype wire

/* sim/qlc_line_ctrl_tb.sv */
// self-checking bench for the line control block
// assumes the bus model supplies the backplane clock and slot pattern
`timescale 1ns/100ps
`default_nettype none
module qlc_line_ctrl_tb;
  import qlc_pkg::*;
  logic        clk_sys = 1'b0, rst = 1'b1, mgmt_clk = 1'b0, mgmt_sel_n = 1'b1, mgmt_din = 1'b0;
  logic [7:0]  line_state = 8'h00, wire_rx_sig = 8'h00, rd = 8'h00;
  logic [31:0] wire_rx_b1 = 32'h0000_00A5, wire_rx_b2 = 32'h0000_005A, wire_tx_b1, wire_tx_b2;
  logic        mgmt_dout, mgmt_dout_oe, int_n, clk_bus, frame_marker, bearer_serial_in;
  logic        bearer_serial_out, bearer_serial_oe, bearer_slot_active_n, signalling_serial_in;
  logic        signalling_serial_out, signalling_serial_oe;
  logic [3:0]  line_power_up, line_detect_enable, wire_tx_oe;
  logic [7:0]  wire_tx_sig;
  logic [8:0]  bit_pos;
  int          fails = 0, n_compared = 0;
  always #4 clk_sys = ~clk_sys;  // 125 MHz
  qlc_line_ctrl dut (.clk_sys, .rst, .mgmt_clk, .mgmt_sel_n, .mgmt_din, .mgmt_dout, .mgmt_dout_oe,
    .int_n, .line_state, .line_power_up, .line_detect_enable, .clk_bus, .frame_marker,
    .bearer_serial_in, .bearer_serial_out, .bearer_serial_oe, .bearer_slot_active_n,
    .signalling_serial_in, .signalling_serial_out, .signalling_serial_oe, .wire_rx_b1,
    .wire_rx_b2, .wire_rx_sig, .wire_tx_b1, .wire_tx_b2, .wire_tx_sig, .wire_tx_oe);
  qlc_bus_model bus (.clk_bus, .frame_marker, .bearer_serial_in, .signalling_serial_in, .bit_pos);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one select: address then data, old contents come back in rd
  task automatic xfer(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] sh;
    sh = {a, d};
    @(posedge clk_sys) mgmt_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mgmt_din <= sh[i];
      repeat (6) @(posedge clk_sys);
      if (i < 8) rd = {rd[6:0], mgmt_dout};  // settled well after the fall
      mgmt_clk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      mgmt_clk <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    mgmt_sel_n <= 1'b1;
    repeat (16) @(posedge clk_bus);  // lets the write cross to the bus side
  endtask
  // bounded wait for frame start or for bearer drive
  task automatic wait_bus(input logic want_oe);
    int k;
    k = 0;
    @(negedge clk_bus);
    while ((want_oe ? bearer_serial_oe : frame_marker) !== 1'b1) begin
      if (++k > 1100) begin fails++; stop_test(); end
      @(negedge clk_bus);
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (6) @(posedge clk_bus);  // long enough for both domains
    @(posedge clk_sys) rst <= 1'b0;
    @(posedge clk_sys);
    chk({int_n, line_power_up, line_detect_enable, wire_tx_oe}, {1'b1, 12'h0F0});
    for (int c = 0; c < 6; c++) begin  // every slot register of line 1, line down
      xfer({4'h1, c[2:0], 1'b0}, 8'hC0 | c[7:0]);
      xfer({4'h1, c[2:0], 1'b1}, 8'h00);
      chk(rd, 8'hC0 | c[7:0]);
    end
    xfer(8'h12, 8'h00);
    chk(rd, 8'hC1);
    xfer(8'h1C, 8'h77);
    xfer(8'h1D, 8'h00);
    chk(rd, 8'h00);
    xfer(8'h2E, 8'h80);
    chk({line_power_up, line_detect_enable}, 8'h4B);
    xfer(8'h0E, 8'h84);
    @(posedge clk_sys) line_state <= 8'h01;
    repeat (4) @(posedge clk_sys);
    chk(int_n, 1'b0);
    xfer(8'hFF, 8'h00);
    chk({rd, int_n}, 9'h003);
    @(posedge clk_sys) line_state <= 8'h41;  // line 3 has interrupts off
    repeat (4) @(posedge clk_sys);
    chk(int_n, 1'b1);
    xfer(8'h08, 8'h83);
    wait_bus(1'b0);
    wait_bus(1'b1);
    chk({bit_pos, bearer_slot_active_n}, {9'd25, 1'b0});
    for (int i = 0; i < 8; i++) begin
      rd = {rd[6:0], bearer_serial_out};
      @(negedge clk_bus);
    end
    chk(rd, 8'hA5);
    xfer(8'h08, 8'h03);
    wait_bus(1'b0);
    rd = 8'h00;
    repeat (32) @(negedge clk_bus) rd |= bearer_serial_oe;  // stop before line 1 claims slot 4
    chk(rd, 8'h00);
    xfer(8'h0E, 8'h90);
    xfer(8'h04, 8'h85);
    wait_bus(1'b0);
    repeat (64) @(negedge clk_bus);
    chk({wire_tx_b1[7:0], wire_tx_b2[7:0]}, 16'hA585);
    xfer(8'h0E, 8'hA0);
    chk({wire_tx_b1[7:0], wire_tx_b2[7:0], wire_tx_sig[1:0]}, 18'h2_9568);
    xfer(8'h0E, 8'h80);
    chk({wire_tx_b1[7:0], wire_tx_sig[1:0]}, {IDLE_BYTE, 2'b10});
    xfer(8'h0E, 8'h82);
    chk(wire_tx_sig[1:0], IDLE_SIG);
    xfer(8'h0E, 8'h20);
    chk(wire_tx_oe[0], 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
